//--- verilog/spcd_decoder.sv
// Serial programming command decoder with on-chip memory models
// ============================================================
// Summary of operation
// - Enable instruction accepted only while reset low
// - Chip erase clears EEPROM and flash
// - Read program word low or high byte
// - Load page buffer byte, low before high
// - Commit page buffer to flash page
// - Read EEPROM byte at ten-bit address
// - Write EEPROM byte directly
// - Load EEPROM page buffer byte
// - Program EEPROM page buffer at page
// - Read lock bits in six low bits
// - Program lock bits written as zero
// - Read signature byte by index
// - Write low, high or extended fuses
// - Read low or high fuse byte
`timescale 1ns/100ps
`default_nettype none
`include "spcd_defs.svh"
module spcd_decoder #(
    parameter int FLASH_WORDS = 256,
    parameter int PAGE_WORDS = 32,
    parameter int EE_BYTES = 64,
    parameter int EE_PAGE = 4,
    parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] SIG1 = 8'h01, // Arbitrary identity value
    parameter logic [7:0] SIG2 = 8'h02  // Arbitrary identity value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Programming link pins
    input wire logic reset_pin_n,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    output logic miso_pin,
    output logic miso_oe,
    // Status
    output logic prog_enabled,
    output spcd_pkg::spcd_byte_t fuse_low,
    output spcd_pkg::spcd_byte_t fuse_high,
    output spcd_pkg::spcd_byte_t fuse_ext,
    output logic [5:0] lock_bits
);
    import spcd_pkg::*;
    localparam int FAW = $clog2(FLASH_WORDS);
    localparam int PAW = $clog2(PAGE_WORDS);
    localparam int EAW = $clog2(EE_BYTES);
    localparam int EPW = $clog2(EE_PAGE);
    initial begin
        if (FAW > 13 || PAW > 6 || PAW >= FAW || EAW > 10 || EPW > 2 || EPW >= EAW) begin
            $error("Memory sizes exceed the instruction address fields");
        end
    end

    // ============================================================
    // Pin synchronisers and clock edge detect
    logic [2:0] sck_s_q;
    logic [1:0] mosi_s_q;
    logic [1:0] rst_s_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_s_q <= 3'h0;
            mosi_s_q <= 2'h0;
            rst_s_q <= 2'h3;
        end else begin
            sck_s_q <= {sck_s_q[1:0], sck_pin};
            mosi_s_q <= {mosi_s_q[0], mosi_pin};
            rst_s_q <= {rst_s_q[0], reset_pin_n};
        end
    end
    wire sck_rise = sck_s_q[1] && !sck_s_q[2];
    wire sck_fall = !sck_s_q[1] && sck_s_q[2];
    wire in_prog = !rst_s_q[1];

    // ============================================================
    // Frame shifter: four bytes MSB first
    logic [31:0] shift_q;
    logic [5:0] bits_q;
    logic [7:0] rd_q;
    logic miso_q;
    wire frame_done = sck_rise && bits_q == `SPCD_FRAME_BITS - 6'd1;
    logic fifo_in_ready;
    always_ff @(posedge clk) begin
        if (srst || !in_prog) begin
            shift_q <= 32'h0;
            bits_q <= 6'h0;
        end else if (sck_rise && fifo_in_ready) begin
            shift_q <= {shift_q[30:0], mosi_s_q[1]};
            bits_q <= frame_done ? 6'h0 : bits_q + 6'd1;
        end
    end
    // Read data goes out during byte four, changing on falling edges
    wire [2:0] out_bit = 3'(6'd7 - (bits_q - 6'd24));
    always_ff @(posedge clk) begin
        if (srst) begin
            miso_q <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= in_prog;
            if (sck_fall && bits_q >= 6'd24) miso_q <= rd_q[out_bit];
            else if (sck_fall) miso_q <= 1'b0;
        end
    end
    assign miso_pin = miso_q;

    // ============================================================
    // Frame FIFO decouples the link from memory writes
    logic [31:0] cmd;
    logic cmd_valid;
    logic cmd_ready;
    spcd_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(frame_done),
        .in_ready(fifo_in_ready),
        .in_data({shift_q[30:0], mosi_s_q[1]}),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd)
    );

    // ============================================================
    // Decode of the byte-three read address while byte three arrives
    wire [7:0] b1 = cmd[31:24];
    wire [7:0] b2 = cmd[23:16];
    wire [7:0] b3 = cmd[15:8];
    wire [7:0] b4 = cmd[7:0];
    // At the 24th rise the last bit of byte three is still on the line, not yet shifted in
    wire [23:0] lhead = {shift_q[22:0], mosi_s_q[1]};
    wire [7:0] l1 = lhead[23:16];
    wire [7:0] l2 = lhead[15:8];
    wire [7:0] l3 = lhead[7:0];
    wire [12:0] l_faddr = {l2[4:0], l3};
    wire [9:0] l_eaddr = {l2[1:0], l3};
    logic [15:0] flash_q [FLASH_WORDS];
    logic [7:0] ee_q [EE_BYTES];
    logic [15:0] pbuf_q [PAGE_WORDS];
    logic [7:0] ebuf_q [EE_PAGE];
    logic enabled_q;
    wire [15:0] rd_word = flash_q[l_faddr[FAW-1:0]];
    wire [7:0] rd_prog = l1[3] ? rd_word[15:8] : rd_word[7:0];
    wire [7:0] rd_sig = (l3[1:0] == 2'd0) ? SIG0 : (l3[1:0] == 2'd1) ? SIG1 : SIG2;
    logic [7:0] rd_sel;
    always_comb begin
        rd_sel = 8'h00;
        if (enabled_q) begin
            if (l1[7:4] == `SPCD_OP_RDPROG && l1[2:0] == 3'h0) rd_sel = rd_prog;
            else if (l1 == `SPCD_OP_RDEE) rd_sel = ee_q[l_eaddr[EAW-1:0]];
            else if (l1 == `SPCD_OP_RDLOCK && l2 == `SPCD_B2_ZERO) rd_sel = {2'b11, lock_bits};
            else if (l1 == `SPCD_OP_RDLOCK && l2 == `SPCD_B2_FUSEH_RD) rd_sel = fuse_high;
            else if (l1 == `SPCD_OP_RDFUSEL && l2 == `SPCD_B2_ZERO) rd_sel = fuse_low;
            else if (l1 == `SPCD_OP_RDSIG) rd_sel = rd_sig;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) rd_q <= 8'h00;
        else if (sck_rise && bits_q == 6'd23) rd_q <= rd_sel;
    end

    // ============================================================
    // Command executor
    spcd_state_t st_q;
    wire is_ena = b1 == `SPCD_OP_ENA_B1 && b2 == `SPCD_OP_ENA_B2;
    wire is_erase = b1 == `SPCD_OP_ENA_B1 && b2[7:5] == `SPCD_OP_ERASE_B2;
    wire is_lockw = b1 == `SPCD_OP_ENA_B1 && b2[7:5] == `SPCD_OP_LOCKW_B2;
    wire is_fusel = b1 == `SPCD_OP_ENA_B1 && b2 == `SPCD_OP_FUSEL_B2;
    wire is_fuseh = b1 == `SPCD_OP_ENA_B1 && b2 == `SPCD_OP_FUSEH_B2;
    wire is_fusex = b1 == `SPCD_OP_ENA_B1 && b2 == `SPCD_OP_FUSEX_B2;
    wire is_ldprog = b1[7:4] == `SPCD_OP_LDPROG && b1[2:0] == 3'h0;
    wire is_wrpage = b1 == `SPCD_OP_WRPAGE;
    wire is_wree = b1 == `SPCD_OP_WREE;
    wire is_ldee = b1 == `SPCD_OP_LDEE;
    wire is_wreepg = b1 == `SPCD_OP_WREEPG;
    wire [12:0] c_faddr = {b2[4:0], b3};
    wire [9:0] c_eaddr = {b2[1:0], b3};
    wire take = cmd_valid && st_q == SPCD_IDLE;
    assign cmd_ready = st_q == SPCD_DONE;
    logic [FAW:0] idx_q;
    wire [FAW:0] erase_last = (FAW+1)'(FLASH_WORDS - 1);
    logic do_erase_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= SPCD_IDLE;
            idx_q <= '0;
            do_erase_q <= 1'b0;
        end else begin
            unique case (st_q)
                SPCD_IDLE: if (take) begin
                    st_q <= SPCD_EXEC;
                    idx_q <= '0;
                    do_erase_q <= enabled_q && is_erase;
                end
                SPCD_EXEC: begin
                    idx_q <= idx_q + 1'b1;
                    if (!do_erase_q || idx_q == erase_last) st_q <= SPCD_DONE;
                end
                SPCD_DONE: st_q <= SPCD_IDLE;
                default: st_q <= SPCD_IDLE;
            endcase
        end
    end
    wire first = st_q == SPCD_EXEC && idx_q == '0 && enabled_q;
    always_ff @(posedge clk) begin
        if (srst || !in_prog) enabled_q <= 1'b0;
        else if (take && is_ena) enabled_q <= 1'b1;
    end
    assign prog_enabled = enabled_q;
    // Fuse and lock state survives link reset; srst restores it, and chip erase also restores the lock bits
    always_ff @(posedge clk) begin
        if (srst) begin
            fuse_low <= `SPCD_FUSE_RST;
            fuse_high <= `SPCD_FUSE_RST;
            fuse_ext <= `SPCD_FUSE_RST;
            lock_bits <= `SPCD_LOCK_RST;
        end else if (first) begin
            if (is_fusel) fuse_low <= b4;
            if (is_fuseh) fuse_high <= b4;
            if (is_fusex) fuse_ext <= b4;
            if (is_lockw) lock_bits <= lock_bits & b4[5:0];
            if (do_erase_q) lock_bits <= `SPCD_LOCK_RST;
        end
    end
    // Erase walks one word per cycle; other writes hit the first cycle only
    wire [FAW-1:0] ew = idx_q[FAW-1:0];
    wire [PAW-1:0] poff = b3[PAW-1:0];
    wire [FAW-1:0] pbase = {c_faddr[FAW-1:PAW], {PAW{1'b0}}};
    wire [EAW-1:0] epbase = {c_eaddr[EAW-1:EPW], {EPW{1'b0}}};
    always_ff @(posedge clk) begin
        if (st_q == SPCD_EXEC && do_erase_q) begin
            flash_q[ew] <= {2{`SPCD_ERASED}};
            if (idx_q < (FAW+1)'(EE_BYTES)) ee_q[ew[EAW-1:0]] <= `SPCD_ERASED;
        end else if (first) begin
            if (is_wrpage) begin
                for (int i = 0; i < PAGE_WORDS; i++) begin
                    flash_q[pbase | FAW'(i)] <= pbuf_q[i];
                end
            end
            if (is_wree) ee_q[c_eaddr[EAW-1:0]] <= b4;
            if (is_wreepg) begin
                for (int j = 0; j < EE_PAGE; j++) begin
                    ee_q[{c_eaddr[EAW-1:EPW], EPW'(j)}] <= ebuf_q[j];
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (first && is_ldprog) begin
            if (b1[3]) pbuf_q[poff][15:8] <= b4;
            else pbuf_q[poff] <= {8'hFF, b4};
        end
        if (first && is_ldee) ebuf_q[b3[EPW-1:0]] <= b4;
    end
    // Any other frame falls through all the decodes above untouched

    // ============================================================
    // Checks
    AST_ENA_NEEDS_RESET: assert property (@(posedge clk) disable iff (srst)
        $rose(enabled_q) |-> $past(in_prog)) else $error("Enable rose outside programming");
    AST_ENA_DROP: assert property (@(posedge clk) disable iff (srst)
        !in_prog |=> !enabled_q) else $error("Enable stayed set after reset release");
    AST_FRAME_LEN: assert property (@(posedge clk) disable iff (srst)
        bits_q < 6'd32) else $error("Bit counter ran past a frame");
    AST_EXEC_BOUND: assert property (@(posedge clk) disable iff (srst)
        (st_q == SPCD_EXEC && !do_erase_q) |=> st_q == SPCD_DONE) else $error("Short command hung");
    AST_FUSE_LOW: assert property (@(posedge clk) disable iff (srst)
        (first && is_fusel) |=> fuse_low == $past(b4)) else $error("Low fuse not written");
    AST_LOCK_ONLY_PROG: assert property (@(posedge clk) disable iff (srst)
        (first && is_lockw) |=> (lock_bits & ~$past(lock_bits)) == 6'h0) else $error("Lock unprogrammed");
    AST_FUSE_STABLE: assert property (@(posedge clk) disable iff (srst)
        !(first && (is_fusel || is_fuseh || is_fusex)) |=> $stable(fuse_high) || $past(do_erase_q))
        else $error("Fuse changed without a fuse frame");
    AST_READ_LOCK: assert property (@(posedge clk) disable iff (srst)
        (sck_rise && bits_q == 6'd23 && enabled_q && l1 == `SPCD_OP_RDLOCK && l2 == 8'h00)
        |=> rd_q[5:0] == lock_bits) else $error("Lock bits not returned");
    AST_SIG_READ: assert property (@(posedge clk) disable iff (srst)
        (sck_rise && bits_q == 6'd23 && enabled_q && l1 == `SPCD_OP_RDSIG && l3[1:0] == 2'd0)
        |=> rd_q == SIG0) else $error("Wrong signature byte");
    COV_ENABLE: cover property (@(posedge clk) $rose(enabled_q));
    COV_ERASE: cover property (@(posedge clk) st_q == SPCD_EXEC && do_erase_q && idx_q == erase_last);
    COV_PAGE: cover property (@(posedge clk) first && is_wrpage);
    COV_FULL: cover property (@(posedge clk) !fifo_in_ready);
    COV_READ: cover property (@(posedge clk) sck_rise && bits_q == 6'd23 && enabled_q);

    // ============================================================
    // Link and read path checks
    AST_ENA_TAKE: assert property (@(posedge clk) disable iff (srst)
        (take && is_ena && in_prog) |=> enabled_q)
        else $error("Enable frame not taken");
    AST_NO_READ_OFF: assert property (@(posedge clk) disable iff (srst)
        (sck_rise && bits_q == 6'd23 && !enabled_q) |=> rd_q == 8'h00)
        else $error("Read data returned while not enabled");
    AST_MISO_IDLE: assert property (@(posedge clk) disable iff (srst)
        (sck_fall && bits_q < 6'd24) |=> !miso_pin)
        else $error("Data out driven outside byte four");
    AST_FRAME_KEPT: assert property (@(posedge clk) disable iff (srst)
        frame_done |-> fifo_in_ready)
        else $error("Frame lost at a full queue");
    AST_READ_PROG: assert property (@(posedge clk) disable iff (srst)
        (sck_rise && bits_q == 6'd23 && enabled_q && l1 == {`SPCD_OP_RDPROG, 4'h0})
        |=> rd_q == $past(flash_q[l_faddr[FAW-1:0]][7:0]))
        else $error("Wrong program low byte");
    AST_READ_EE: assert property (@(posedge clk) disable iff (srst)
        (sck_rise && bits_q == 6'd23 && enabled_q && l1 == `SPCD_OP_RDEE)
        |=> rd_q == $past(ee_q[l_eaddr[EAW-1:0]]))
        else $error("Wrong EEPROM byte");
    AST_FUSE_HIGH_RD: assert property (@(posedge clk) disable iff (srst)
        (sck_rise && bits_q == 6'd23 && enabled_q && l1 == `SPCD_OP_RDLOCK
        && l2 == `SPCD_B2_FUSEH_RD) |=> rd_q == $past(fuse_high))
        else $error("Wrong high fuse byte");

    // ============================================================
    // Write path checks
    AST_ERASE_FLASH: assert property (@(posedge clk) disable iff (srst)
        (st_q == SPCD_EXEC && do_erase_q) |=> flash_q[$past(ew)] == {2{`SPCD_ERASED}})
        else $error("Erase left a flash word");
    AST_ERASE_LEN: assert property (@(posedge clk) disable iff (srst)
        (st_q == SPCD_EXEC && do_erase_q && idx_q == erase_last) |=> st_q == SPCD_DONE)
        else $error("Erase sweep did not end");
    AST_LOCK_ERASE: assert property (@(posedge clk) disable iff (srst)
        (first && do_erase_q) |=> lock_bits == `SPCD_LOCK_RST)
        else $error("Erase kept lock bits");
    AST_LOAD_LOW: assert property (@(posedge clk) disable iff (srst)
        (first && is_ldprog && !b1[3]) |=> pbuf_q[$past(poff)] == {8'hFF, $past(b4)})
        else $error("Page buffer low byte not loaded");
    AST_PAGE_COMMIT: assert property (@(posedge clk) disable iff (srst)
        (first && is_wrpage) |=> flash_q[$past(pbase)] == $past(pbuf_q[0]))
        else $error("Page not committed");
    AST_WRITE_EE: assert property (@(posedge clk) disable iff (srst)
        (first && is_wree) |=> ee_q[$past(c_eaddr[EAW-1:0])] == $past(b4))
        else $error("EEPROM byte not written");
    AST_LOAD_EE: assert property (@(posedge clk) disable iff (srst)
        (first && is_ldee) |=> ebuf_q[$past(b3[EPW-1:0])] == $past(b4))
        else $error("EEPROM page buffer not loaded");
    AST_EE_PAGE: assert property (@(posedge clk) disable iff (srst)
        (first && is_wreepg) |=> ee_q[$past(epbase)] == $past(ebuf_q[0]))
        else $error("EEPROM page not written");
    AST_FUSE_HIGH_WR: assert property (@(posedge clk) disable iff (srst)
        (first && is_fuseh) |=> fuse_high == $past(b4))
        else $error("High fuse not written");
    AST_LOCK_STABLE: assert property (@(posedge clk) disable iff (srst)
        !(first && (is_lockw || do_erase_q)) |=> $stable(lock_bits))
        else $error("Lock bits changed without a lock frame");
endmodule : spcd_decoder
`default_nettype wire

//--- verilog/spcd_defs.svh
// Constants for the serial programming command decoder
`ifndef SPCD_DEFS_SVH
`define SPCD_DEFS_SVH
`define SPCD_OP_ENA_B1 8'hAC
`define SPCD_OP_ENA_B2 8'h53
`define SPCD_OP_ERASE_B2 3'h4
`define SPCD_OP_LOCKW_B2 3'h7
`define SPCD_OP_FUSEL_B2 8'hA0
`define SPCD_OP_FUSEH_B2 8'hA8
`define SPCD_OP_FUSEX_B2 8'hA4
`define SPCD_OP_RDPROG 4'h2
`define SPCD_OP_LDPROG 4'h4
`define SPCD_OP_WRPAGE 8'h4C
`define SPCD_OP_RDEE 8'hA0
`define SPCD_OP_WREE 8'hC0
`define SPCD_OP_LDEE 8'hC1
`define SPCD_OP_WREEPG 8'hC2
`define SPCD_OP_RDLOCK 8'h58
`define SPCD_OP_RDSIG 8'h30
`define SPCD_OP_RDFUSEL 8'h50
`define SPCD_B2_ZERO 8'h00
`define SPCD_B2_FUSEH_RD 8'h08
`define SPCD_FUSE_RST 8'hFF
`define SPCD_LOCK_RST 6'h3F
`define SPCD_ERASED 8'hFF
`define SPCD_FRAME_BITS 6'd32
`endif

//--- verilog/spcd_pkg.sv
// Types for the serial programming command decoder
`default_nettype none
package spcd_pkg;
    typedef logic [7:0] spcd_byte_t;
    typedef enum logic [1:0] {
        SPCD_IDLE = 2'b00,
        SPCD_EXEC = 2'b01,
        SPCD_DONE = 2'b11
    } spcd_state_t;
endpackage : spcd_pkg
`default_nettype wire

//--- verilog/spcd_fifo.sv
// Small valid/ready FIFO in flip-flops
`timescale 1ns/100ps
`default_nettype none
module spcd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("DEPTH must be a power of two of at least 2");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule : spcd_fifo
`default_nettype wire

//--- verification/spcd_programmer.sv
// Programmer model that drives the serial programming link
`timescale 1ns/100ps
`default_nettype none
module spcd_programmer (
    // Pacing clock
    input wire logic clk,
    // Link pins
    output logic reset_pin_n,
    output logic sck_pin,
    output logic mosi_pin,
    input wire logic miso_pin
);
    // Half link period in system clocks: 4 gives 40 ns (an 80 ns link period), larger values slow the link
    int half = 4;
    initial begin
        reset_pin_n = 1'b1;
        sck_pin = 1'b0;
        mosi_pin = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic set_reset(input logic v);
        tick(1);
        reset_pin_n = v;
        tick(8);
    endtask : set_reset
    // Clock stays low between frames; a released data line shows the inverse, not the last bit
    task automatic send(input logic [31:0] f, input int nbits, input int gap,
                        output logic [7:0] rd);
        rd = 8'h00;
        tick(1);
        for (int i = 31; i > 31 - nbits; i--) begin
            mosi_pin = f[i];
            tick(half);
            sck_pin = 1'b1;
            tick(half);
            if (i < 8) begin
                rd = {rd[6:0], miso_pin};
            end
            sck_pin = 1'b0;
        end
        mosi_pin = ~mosi_pin;
        tick(gap);
    endtask : send
endmodule : spcd_programmer
`default_nettype wire

//--- verification/spcd_decoder_bench.sv
// Self-checking bench for the serial programming command decoder
`timescale 1ns/100ps
`default_nettype none
module spcd_decoder_bench;
    import spcd_pkg::*;
    // Arbitrary identity values
    localparam spcd_byte_t SIG[4] = '{8'hC3, 8'h96, 8'h69, 8'h69};
    localparam spcd_byte_t B2F[3] = '{8'hA0, 8'hA8, 8'hA4};
    localparam spcd_byte_t UNK[4] = '{8'hFF, 8'h11, 8'h6A, 8'hAC};
    logic clk, srst, reset_pin_n, sck_pin, mosi_pin, miso_pin, miso_oe, prog_enabled;
    spcd_byte_t fuse_low, fuse_high, fuse_ext, rd;
    logic [5:0] lock_bits, lock_m;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'h056c617b;
    logic [15:0] flash_m [256];
    spcd_byte_t ee_m [64];
    spcd_byte_t fz [3];
    // ==========================================
    // Harness
    spcd_decoder #(.SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2])) i_dut (
        .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .sck_pin(sck_pin),
        .mosi_pin(mosi_pin), .miso_pin(miso_pin), .miso_oe(miso_oe),
        .prog_enabled(prog_enabled), .fuse_low(fuse_low), .fuse_high(fuse_high),
        .fuse_ext(fuse_ext), .lock_bits(lock_bits));
    spcd_programmer i_prog (.clk(clk), .reset_pin_n(reset_pin_n), .sck_pin(sck_pin),
        .mosi_pin(mosi_pin), .miso_pin(miso_pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic spcd_byte_t rnd();
        return spcd_byte_t'($random(seed));
    endfunction : rnd
    function automatic spcd_byte_t exp_flash(input spcd_byte_t w, input logic h);
        return h ? flash_m[w][15:8] : flash_m[w][7:0];
    endfunction : exp_flash
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(input spcd_byte_t b1, b2, b3, b4, input int gap = 8);
        i_prog.send({b1, b2, b3, b4}, 32, gap, rd);
    endtask : cmd
    task automatic rdchk(input string what, input spcd_byte_t b1, b2, b3, exp);
        cmd(b1, b2, b3, 8'h00);
        chk(what, {8'h00, exp}, {8'h00, rd});
    endtask : rdchk
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    // ==========================================
    // Scenarios
    initial begin
        spcd_byte_t a, d, p;
        spcd_byte_t pb [4];
        srst = 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        chk("reset state", 16'hFF3F, {fuse_low, 2'b00, lock_bits});
        // Enable with the reset pin high must not be taken
        cmd(8'hAC, 8'h53, rnd(), rnd());
        chk("enabled", 16'h0000, {14'h0000, miso_oe, prog_enabled});
        i_prog.set_reset(1'b0);
        cmd(8'hAC, 8'hA0, rnd(), 8'h00);
        chk("fuse_low", 16'h00FF, {8'h00, fuse_low});
        // A frame cut by the reset pin must not shift the next one
        i_prog.send(32'hAC53_0000, 13, 8, rd);
        i_prog.set_reset(1'b1);
        i_prog.set_reset(1'b0);
        cmd(8'hAC, 8'h53, rnd(), rnd());
        chk("enabled", 16'h0003, {14'h0000, miso_oe, prog_enabled});
        // Erase runs for a whole flash sweep, so leave room before the next frame
        cmd(8'hAC, 8'h80 | (rnd() & 8'h1F), rnd(), rnd(), 400);
        foreach (flash_m[i]) flash_m[i] = 16'hFFFF;
        foreach (ee_m[i]) ee_m[i] = 8'hFF;
        lock_m = 6'h3F;
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            rdchk("flash hi", 8'h28, 8'h00, a, exp_flash(a, 1'b1));
            rdchk("eeprom", 8'hA0, 8'h00, a & 8'h3F, ee_m[a[5:0]]);
        end
        // Back-to-back page loads, then reads with a slowed link
        p = rnd() & 8'hE0;
        for (int o = 0; o < 32; o++) begin
            a = rnd();
            d = rnd();
            cmd(8'h40, 8'h00, 8'(o), a, 0);
            cmd(8'h48, 8'h00, 8'(o), d, 0);
            flash_m[p | 8'(o)] = {d, a};
        end
        cmd(8'h4C, 8'h00, p, 8'h00);
        i_prog.half = 8;
        for (int i = 0; i < 6; i++) begin
            a = p | (rnd() & 8'h1F);
            rdchk("flash lo", 8'h20, 8'h00, a, exp_flash(a, 1'b0));
            rdchk("flash hi", 8'h28, 8'h00, a, exp_flash(a, 1'b1));
        end
        i_prog.half = 4;
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 8'h3F : (i == 1) ? 8'h00 : rnd() & 8'h3F;
            d = rnd();
            cmd(8'hC0, 8'h00, a, d, 0);
            ee_m[a[5:0]] = d;
            rdchk("eeprom", 8'hA0, 8'h00, a, d);
        end
        // Page buffer must stay out of the array until the page command
        p = rnd() & 8'h3C;
        for (int o = 0; o < 4; o++) begin
            pb[o] = rnd();
            cmd(8'hC1, 8'h00, 8'(o), pb[o]);
        end
        rdchk("ee early", 8'hA0, 8'h00, p, ee_m[p[5:0]]);
        cmd(8'hC2, 8'h00, p, 8'h00, 40);
        for (int o = 0; o < 4; o++) begin
            ee_m[p[5:0] | 6'(o)] = pb[o];
            rdchk("ee page", 8'hA0, 8'h00, p | 8'(o), pb[o]);
        end
        for (int i = 0; i < 3; i++) begin
            d = rnd() | 8'h15;
            cmd(8'hAC, 8'hE0 | (rnd() & 8'h1F), rnd(), d);
            lock_m = lock_m & d[5:0];
            chk("lock_bits", {10'h000, lock_m}, {10'h000, lock_bits});
            rdchk("lock rd", 8'h58, 8'h00, rnd(), {2'b11, lock_m});
        end
        for (int k = 0; k < 3; k++) begin
            fz[k] = rnd();
            cmd(8'hAC, B2F[k], rnd(), fz[k]);
        end
        chk("fuses", {fz[0], fz[1]}, {fuse_low, fuse_high});
        chk("fuse_ext", {8'h00, fz[2]}, {8'h00, fuse_ext});
        rdchk("fuse lo rd", 8'h50, 8'h00, rnd(), fz[0]);
        rdchk("fuse hi rd", 8'h58, 8'h08, rnd(), fz[1]);
        for (int i = 0; i < 4; i++) begin
            rdchk("signature", 8'h30, rnd() & 8'h1F, (rnd() & 8'hFC) | 8'(i), SIG[i]);
        end
        for (int i = 0; i < 4; i++) begin
            cmd(UNK[i], (i == 3) ? 8'h00 : rnd(), rnd(), rnd());
        end
        chk("fuses", {fz[0], fz[1]}, {fuse_low, fuse_high});
        chk("lock_bits", {10'h000, lock_m}, {10'h000, lock_bits});
        rdchk("eeprom", 8'hA0, 8'h00, p, ee_m[p[5:0]]);
        rdchk("flash hi", 8'h28, 8'h00, a, exp_flash(a, 1'b1));
        i_prog.set_reset(1'b1);
        chk("enabled", 16'h0000, {14'h0000, miso_oe, prog_enabled});
        end_sim();
    end
endmodule : spcd_decoder_bench
`default_nettype wire
